// ---- inc/pwr_seq_pkg.sv ----
// Constants and types for the power-on and battery sequencer
package pwr_seq_pkg;
	localparam int unsigned CLK_HZ         = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS  = 40;
	// Battery check window after wake-up, microseconds
	localparam int unsigned BATT_CHECK_US  = 1000;
	localparam int unsigned BATT_CHECK_CYC =
		(BATT_CHECK_US * 1000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// Crystal-derived timebase, nominal 32 kHz (32768 Hz)
	localparam int unsigned XTAL_HZ        = 32_768;
	localparam int unsigned SYNC_STAGES    = 2;
	localparam int unsigned WAIT_W         = 16;
	// Idle pin pattern after sync: active-low pins high
	localparam logic [6:0]  SYNC_IDLE      = 7'h1A;
	localparam logic        LVL_ON         = 1'b1;
	localparam logic        LVL_OFF        = 1'b0;

	typedef enum logic [2:0] {
		ST_HIBERNATE,
		ST_WAKE,
		ST_CHECK,
		ST_RUN,
		ST_SHUTDOWN
	} seq_state_t;
endpackage

// ---- rtl/input_sync.sv ----
// Two-flip-flop synchroniser bank for asynchronous board inputs
`timescale 1ns/1ns
`default_nettype none
module input_sync #(
	parameter int unsigned WIDTH = 1,
	parameter logic [WIDTH-1:0] RST_VAL = '0
) (
	// Clock and reset
	input  wire logic             clk,
	input  wire logic             rst,
	// Async in, synchronised out
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	always_ff @(posedge clk) begin
		if (rst) begin
			meta_q   <= RST_VAL;
			sync_out <= RST_VAL;
		end else begin
			meta_q   <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule // input_sync
`default_nettype wire

// ---- rtl/power_on_battery_sequencer.sv ----
// Power-on, wake-up and battery supervision sequencer
`timescale 1ns/1ns
`default_nettype none
module power_on_battery_sequencer
	import pwr_seq_pkg::*;
#(
	parameter int unsigned CHECK_CYC = BATT_CHECK_CYC,
	parameter int unsigned TICK_DIV  = CLK_HZ / XTAL_HZ
) (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Crystal pins
	input  wire logic xtal_in_a,
	input  wire logic xtal_in_b,
	// Board switches and battery monitor
	input  wire logic on_switch_in,
	input  wire logic reset_switch_n,
	input  wire logic battery_ok_in,
	input  wire logic battery_low_int_n,
	input  wire logic clock_calendar_clear_n,
	// Outputs to board
	output logic      supply_enable_out,
	output logic      wake_state_out,
	// Outputs to processor core
	output logic      battery_low_irq,
	output logic      battery_fail,
	output logic      core_reset,
	output logic      calendar_reset,
	output logic      tick_32k,
	output logic      running
);
	import pwr_seq_pkg::*;

	localparam int unsigned NIN = 7;
	localparam int unsigned DW  = (TICK_DIV > 1) ? $clog2(TICK_DIV) : 1;
	localparam int unsigned CW  = $clog2(CHECK_CYC + 1);

	// Synchronised inputs; active-low pins idle high
	logic [NIN-1:0] raw_in;
	logic [NIN-1:0] syn;
	assign raw_in = {xtal_in_b, xtal_in_a, clock_calendar_clear_n,
		battery_low_int_n, battery_ok_in, reset_switch_n, on_switch_in};

	input_sync #(
		.WIDTH   (NIN),
		.RST_VAL (SYNC_IDLE)
	) u_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (raw_in),
		.sync_out (syn)
	);

	// Active-high view of each pin; idle pattern gives all zero
	logic [NIN-1:0] act;

	for (genvar i = 0; i < NIN; i++) begin : g_pol
		assign act[i] = syn[i] ^ SYNC_IDLE[i];
	end

	// Decoded pin meanings
	wire on_sw      = act[0];
	wire rst_sw     = act[1];
	wire batt_ok    = act[2];
	wire batt_low   = act[3];
	wire cal_clr    = act[4];
	wire xtal_level = act[5] ^ act[6];

	// 32-kHz timebase: crystal edges, else divider fallback
	// Divider covers a crystal that has not toggled since reset; one that stops after an edge stalls the check
	logic          xtal_prev_q;
	logic [DW-1:0] div_q;
	logic          xtal_seen_q;
	wire           xtal_edge = xtal_level & ~xtal_prev_q;
	wire           div_wrap  = (div_q == DW'(TICK_DIV - 1));
	wire           tick      = xtal_seen_q ? xtal_edge : div_wrap;

	always_ff @(posedge clk) begin
		if (rst) begin
			xtal_prev_q <= LVL_OFF;
			div_q       <= '0;
			xtal_seen_q <= LVL_OFF;
		end else begin
			xtal_prev_q <= xtal_level;
			div_q       <= div_wrap ? '0 : DW'(div_q + 1'b1);
			if (xtal_edge)
				xtal_seen_q <= LVL_ON;
		end
	end

	// Sequencer
	seq_state_t    state_q, state_d;
	logic [CW-1:0] cnt_q, cnt_d;
	logic          wake_q, supply_q, fail_q, irq_q, tick_q;
	logic          on_prev_q;
	logic          run_q, core_rst_q;

	// Press edge; presses outside hibernation are ignored
	wire on_press  = on_sw & ~on_prev_q;
	// Check ends on the tick that completes the window
	wire check_end = (cnt_q == CW'(CHECK_CYC - 1));

	// Current state decode
	wire in_hib     = (state_q == ST_HIBERNATE);
	wire in_check   = (state_q == ST_CHECK);
	wire in_run     = (state_q == ST_RUN);

	// Next state decode, plus failure and low-battery events
	wire next_hib   = (state_d == ST_HIBERNATE);
	wire next_wake  = (state_d == ST_WAKE);
	wire next_check = (state_d == ST_CHECK);
	wire next_run   = (state_d == ST_RUN);
	wire next_down  = (state_d == ST_SHUTDOWN);
	wire fail_set   = in_check && next_hib;
	wire low_event  = in_run && batt_low;

	always_comb begin
		state_d = state_q;
		cnt_d   = cnt_q;
		case (state_q)
			ST_HIBERNATE: begin
				cnt_d = '0;
				if (on_press)
					state_d = ST_WAKE;
			end
			ST_WAKE: begin
				cnt_d   = '0;
				state_d = ST_CHECK;
			end
			ST_CHECK: begin
				if (tick)
					cnt_d = CW'(cnt_q + 1'b1);
				if (check_end && tick)
					state_d = batt_ok ? ST_RUN : ST_HIBERNATE;
			end
			ST_RUN: begin
				if (rst_sw)
					state_d = ST_WAKE;
				else if (batt_low)
					state_d = ST_SHUTDOWN;
			end
			ST_SHUTDOWN: begin
				if (!batt_low)
					state_d = ST_HIBERNATE;
			end
			default: state_d = ST_HIBERNATE;
		endcase
		// Calendar clear beats every other request
		if (cal_clr)
			state_d = ST_HIBERNATE;
	end

	wire wake_d   = next_wake || next_check;
	wire supply_d = !next_hib && !next_down;
	// Sticky failure flag: a failing check beats the clearing press
	wire fail_d   = fail_set ? LVL_ON :
		((on_press && in_hib) ? LVL_OFF : fail_q);
	// Core stays in reset until the check has passed
	wire core_d   = ~supply_d | wake_d;

	// State and check counter
	always_ff @(posedge clk) begin
		if (rst) begin
			state_q <= ST_HIBERNATE;
			cnt_q   <= '0;
		end else begin
			state_q <= state_d;
			cnt_q   <= cnt_d;
		end
	end

	// Registered status outputs
	always_ff @(posedge clk) begin
		if (rst) begin
			wake_q     <= LVL_OFF;
			supply_q   <= LVL_OFF;
			fail_q     <= LVL_OFF;
			irq_q      <= LVL_OFF;
			run_q      <= LVL_OFF;
			core_rst_q <= LVL_ON;
		end else begin
			wake_q     <= wake_d;
			supply_q   <= supply_d;
			fail_q     <= fail_d;
			irq_q      <= low_event;
			run_q      <= next_run;
			core_rst_q <= core_d;
		end
	end

	// Registered tick output and switch edge history
	always_ff @(posedge clk) begin
		if (rst) begin
			tick_q    <= LVL_OFF;
			on_prev_q <= LVL_OFF;
		end else begin
			tick_q    <= tick;
			on_prev_q <= on_sw;
		end
	end

	// Port drive
	assign wake_state_out    = wake_q;
	assign supply_enable_out = supply_q;
	assign battery_low_irq   = irq_q;
	assign battery_fail      = fail_q;
	assign core_reset        = core_rst_q;
	assign calendar_reset    = cal_clr;
	assign tick_32k          = tick_q;
	assign running           = run_q;
endmodule // power_on_battery_sequencer
`default_nettype wire

// ---- tb/pwr_seq_asserts.sv ----
// Checker for the power sequencer ports
`timescale 1ns/1ns
`default_nettype none
module pwr_seq_asserts (
	input wire logic clk, rst, on_switch_in, battery_low_int_n,
	input wire logic supply_enable_out, wake_state_out, running,
	input wire logic battery_low_irq, calendar_reset, tick_32k
);
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence s_press;
		$rose(on_switch_in) && !supply_enable_out && !calendar_reset;
	endsequence
	sequence s_off;
		battery_low_irq ##[0:4] !supply_enable_out;
	endsequence
	property p_wake; s_press |-> ##[3:5] wake_state_out; endproperty
	property p_sync; $rose(on_switch_in) |=> $stable(wake_state_out); endproperty
	property p_sup; $rose(wake_state_out) |-> supply_enable_out; endproperty
	property p_run; running |-> !wake_state_out && supply_enable_out; endproperty
	property p_low; running && !battery_low_int_n |-> ##[1:4] s_off; endproperty
	property p_tick; tick_32k |=> !tick_32k; endproperty
	a_wake: assert property (p_wake) else $error("no wake");
	a_sync: assert property (p_sync) else $error("unsynced");
	a_sup: assert property (p_sup) else $error("no supply");
	a_run: assert property (p_run) else $error("bad run");
	a_low: assert property (p_low) else $error("no low irq");
	a_tick: assert property (p_tick) else $error("long tick");
endmodule // pwr_seq_asserts
bind power_on_battery_sequencer pwr_seq_asserts i_pwr_seq_asserts (.*);
`default_nettype wire

// ---- tb/board_model.sv ----
// Board side: switches, battery monitor, crystal
`timescale 1ns/1ns
`default_nettype none
module board_model #(parameter int unsigned CAL_CYC = 40) (
	input wire logic clk, press, good, low, rsw,
	output logic xtal_in_a, xtal_in_b, on_switch_in, reset_switch_n,
	output logic battery_ok_in, battery_low_int_n, clock_calendar_clear_n
);
	int unsigned n = 0;
	initial begin
		{xtal_in_a, xtal_in_b, on_switch_in, battery_ok_in} = '0;
		{reset_switch_n, battery_low_int_n, clock_calendar_clear_n} = '1;
	end
	always @(posedge clk) begin
		n <= n + 1;
		xtal_in_a <= n[3];
		clock_calendar_clear_n <= (n >= CAL_CYC);
		on_switch_in <= press;
		reset_switch_n <= !rsw;
		battery_ok_in <= good;
		battery_low_int_n <= !low;
	end
endmodule // board_model
`default_nettype wire

// ---- tb/test_power_on_battery_sequencer.sv ----
// Self-checking bench for the power sequencer
`timescale 1ns/1ns
`default_nettype none
module test_power_on_battery_sequencer;
	logic clk = 0, rst = 1, press = 0, good = 0, low = 0, rsw = 0;
	logic xtal_in_a, xtal_in_b, on_switch_in, reset_switch_n;
	logic battery_ok_in, battery_low_int_n, clock_calendar_clear_n;
	logic supply_enable_out, wake_state_out, battery_low_irq;
	logic battery_fail, core_reset, calendar_reset, tick_32k, running;
	int errors = 0, num_checks = 0;
	initial forever #20 clk = ~clk;
	board_model i_board_model (.*);
	power_on_battery_sequencer #(.CHECK_CYC(4), .TICK_DIV(4))
		i_power_on_battery_sequencer (.*);
	task final_report;
		$display("errors=%0d checks=%0d", errors, num_checks);
		if (errors == 0 && num_checks > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask
	task chk(input logic c, input string m);
		num_checks++;
		if (c !== 1'b1) begin
			errors++;
			$display("CHECK FAILED %0t %s", $time, m);
		end
	endtask
	task automatic wt(ref logic s, input logic v);
		for (int i = 0; i < 600 && s !== v; i++) @(posedge clk);
		chk(s === v, "wait ran out");
		if (s !== v) final_report();
	endtask
	task t_boot;
		good <= 1;
		press <= 1;
		wt(wake_state_out, 1);
		chk(supply_enable_out === 1, "supply off");
		chk(core_reset === 1, "core free early");
		press <= 0;
		wt(running, 1);
		chk(wake_state_out === 0, "wake stuck");
		chk(core_reset === 0, "core held");
		chk(battery_fail === 0, "fail set");
	endtask
	task t_rsw;
		rsw <= 1;
		wt(wake_state_out, 1);
		rsw <= 0;
		wt(running, 1);
	endtask
	task t_low;
		low <= 1;
		wt(battery_low_irq, 1);
		wt(supply_enable_out, 0);
		low <= 0;
		repeat (8) @(posedge clk);
	endtask
	task t_fail;
		good <= 0;
		press <= 1;
		wt(wake_state_out, 1);
		press <= 0;
		wt(wake_state_out, 0);
		chk(battery_fail === 1, "no fail");
		chk(supply_enable_out === 0, "supply on");
	endtask
	initial begin
		repeat (5) @(posedge clk);
		rst <= 0;
		wt(calendar_reset, 1);
		wt(calendar_reset, 0);
		wt(tick_32k, 1);
		repeat (3) @(posedge clk);
		t_boot();
		t_rsw();
		t_low();
		t_fail();
		t_boot();
		final_report();
	end
endmodule // test_power_on_battery_sequencer
`default_nettype wire
